// *** rcf_reset_cause_flags.sv ***
// reset cause flag register with apb slave and software reset triggers
`timescale 1ns/10ps
// Operation
// R1 - deep-off flag set only on deep-off wake
// R2 - main supply failure clears deep-off flag
// R3 - high flag: supply below high, above brownout
// R4 - core flag: core low, supply above high
// R5 - soft power-on flag set by soft request
// R6 - reset pin flag set by reset pin
// R7 - soft brownout flag set by soft request
// R8 - flags loaded by write, cleared by vector read
// R9 - reserved bits read zero, ignore writes
// R10 - flags forwarded to system nmi generator
// R11 - soft power-on trigger starts reset, self-clears
// R12 - flags survive the resets they record
module rcf_reset_cause_flags
  import rcf_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // clock and resets
  input wire logic clock,
  input wire logic rst_n,
  input wire logic porRst_n,
  input wire logic clockEnable,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // reset sources, asynchronous levels
  input wire rcf_cause_t causeIn,
  // reset vector word read, same clock pulse
  input wire logic vectorRead,
  // reset requests and enables
  output rcf_req_t resetReq,
  output logic highSupEnable,
  output logic coreSupEnable,
  // flags toward system nmi vector
  output logic [15:0] nmiFlags,
  output logic nmiFlagAny
);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (ADDR_W < 11) begin : gAddrCheck
    $error("ADDR_W too small for register map");
  end
  if (ADDR_W > 32) begin : gAddrMaxCheck
    $error("ADDR_W wider than the bus");
  end
  if (RCF_SYNC_STAGES != 2) begin : gSyncCheck
    $error("synchroniser depth must be two");
  end

  // ----------------------------------------
  // field position checks
  // ----------------------------------------
  localparam logic [15:0] FLAG_BITS = 16'(
    (1 << RCF_DEEP_OFF_BIT) | (1 << RCF_HIGH_SUP_BIT) | (1 << RCF_CORE_SUP_BIT) |
    (1 << RCF_SOFT_POR_BIT) | (1 << RCF_RST_PIN_BIT) | (1 << RCF_SOFT_BOR_BIT));
  localparam logic [15:0] CTRL_BITS = 16'((1 << RCF_HIGH_EN_BIT) | (1 << RCF_CORE_EN_BIT));
  localparam logic [15:0] TRIG_BITS = 16'(
    (1 << RCF_SOFT_POR_TRIG_BIT) | (1 << RCF_SOFT_BOR_TRIG_BIT));

  if (FLAG_BITS != RCF_FLAGS_MASK) begin : gFlagMaskCheck
    $error("flag mask disagrees with flag positions");
  end
  if (CTRL_BITS != RCF_CTRL_MASK) begin : gCtrlMaskCheck
    $error("control mask disagrees with enable positions");
  end
  if ((TRIG_BITS & RCF_CTRL_MASK) != 16'h0000) begin : gTrigCheck
    $error("trigger bits must read as zero");
  end
  if (RCF_SOFT_POR_TRIG_BIT > 7 || RCF_SOFT_BOR_TRIG_BIT > 7) begin : gLaneCheck
    $error("trigger bits must sit in the low lane");
  end
  if ((RCF_CTRL_RESET & ~RCF_CTRL_MASK) != 16'h0000) begin : gCtrlResetCheck
    $error("control reset value outside its mask");
  end
  if ((RCF_FLAGS_RESET & ~RCF_FLAGS_MASK) != 16'h0000) begin : gFlagResetCheck
    $error("flag reset value outside its mask");
  end
  if (RCF_CTRL_ADDR == RCF_FLAGS_ADDR) begin : gMapCheck
    $error("registers share an address");
  end
  if (RCF_CTRL_ADDR[1:0] != 2'b00 || RCF_FLAGS_ADDR[1:0] != 2'b00) begin : gAlignCheck
    $error("register addresses must be word aligned");
  end

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  localparam int NC = $bits(rcf_cause_t);
  logic [NC-1:0] syncA_r;
  logic [NC-1:0] syncB_r;
  rcf_cause_t cause;

  genvar gi;
  generate
    for (gi = 0; gi < NC; gi++) begin : gSync
      always_ff @(posedge clock or negedge porRst_n) begin
        if (!porRst_n) begin
          syncA_r[gi] <= 1'b0;
          syncB_r[gi] <= 1'b0;
        end else if (clockEnable) begin
          syncA_r[gi] <= causeIn[gi];
          syncB_r[gi] <= syncA_r[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // synchronised causes
  // ----------------------------------------
  assign cause = rcf_cause_t'(syncB_r);

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire setupPhase = psel && !penable;
  wire accessDone = psel && penable && pready;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  wire hitCtrl = paddr[9:0] == RCF_CTRL_ADDR && paddr[ADDR_W-1:10] == '0;
  wire hitFlags = paddr[9:0] == RCF_FLAGS_ADDR && paddr[ADDR_W-1:10] == '0;
  wire hitAny = hitCtrl || hitFlags;
  wire wrCtrl = accessDone && pwrite && hitCtrl;
  wire wrFlags = accessDone && pwrite && hitFlags;
  wire [1:0] laneEn = pstrb[1:0];

  // ----------------------------------------
  // control register
  // ----------------------------------------
  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  rcf_req_t req_r;
  rcf_req_t req_nxt;

  // ----------------------------------------
  // control write merge
  // ----------------------------------------
  wire [15:0] wrMerged = {
    laneEn[1] ? pwdata[15:8] : ctrl_r[15:8],
    laneEn[0] ? pwdata[7:0] : ctrl_r[7:0]
  };

  assign ctrl_nxt = wrCtrl ? (wrMerged & RCF_CTRL_MASK) : ctrl_r;

  // ----------------------------------------
  // software reset requests
  // ----------------------------------------
  // trigger bits read zero, so they give a one-cycle request
  assign req_nxt.softPorReq = wrCtrl && laneEn[0] && pwdata[RCF_SOFT_POR_TRIG_BIT]; // R11
  assign req_nxt.softBorReq = wrCtrl && laneEn[0] && pwdata[RCF_SOFT_BOR_TRIG_BIT];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= RCF_CTRL_RESET;
      req_r <= '0;
    end else if (clockEnable) begin
      ctrl_r <= ctrl_nxt;
      req_r <= req_nxt; // R11
    end
  end

  wire highEn = ctrl_r[RCF_HIGH_EN_BIT];

  // ----------------------------------------
  // flag set terms
  // ----------------------------------------
  logic [15:0] flags_r;
  logic [15:0] flags_nxt;
  logic [15:0] setVec;
  logic [15:0] kept;

  wire mainFail = cause.brownout || (cause.highSupTrip && highEn);
  wire setDeep = cause.deepOffWake && !mainFail; // R1
  wire setHigh = cause.highSupTrip && !cause.brownout; // R3
  wire setCore = cause.coreSupTrip && !cause.highSupTrip; // R4
  wire setPor = req_nxt.softPorReq; // R5
  wire setPin = cause.resetPin; // R6
  wire setBor = req_nxt.softBorReq; // R7

  always_comb begin
    setVec = '0;
    setVec[RCF_DEEP_OFF_BIT] = setDeep; // R1
    setVec[RCF_HIGH_SUP_BIT] = setHigh; // R3
    setVec[RCF_CORE_SUP_BIT] = setCore; // R4
    setVec[RCF_SOFT_POR_BIT] = setPor; // R5
    setVec[RCF_RST_PIN_BIT] = setPin; // R6
    setVec[RCF_SOFT_BOR_BIT] = setBor; // R7
  end

  // ----------------------------------------
  // flag clear terms
  // ----------------------------------------
  wire flagWrLo = wrFlags && laneEn[0];
  wire flagWrHi = wrFlags && laneEn[1];
  wire clrDeep = mainFail; // R2

  always_comb begin
    kept = flags_r;
    if (vectorRead) begin
      kept = '0; // R8
    end
    if (flagWrHi) begin
      kept[15:8] = pwdata[15:8]; // R8
    end
    if (flagWrLo) begin
      kept[7:0] = pwdata[7:0];
    end
    if (clrDeep) begin
      kept[RCF_DEEP_OFF_BIT] = 1'b0; // R2
    end
  end

  // ----------------------------------------
  // flag next value
  // ----------------------------------------
  // set wins over any clear
  assign flags_nxt = (kept | setVec) & RCF_FLAGS_MASK; // R9

  // ----------------------------------------
  // flag storage
  // ----------------------------------------
  // of the two resets, only the power-on reset clears the flags
  always_ff @(posedge clock or negedge porRst_n) begin
    if (!porRst_n) begin
      flags_r <= RCF_FLAGS_RESET;
    end else if (clockEnable) begin
      flags_r <= flags_nxt; // R12
    end
  end

  // ----------------------------------------
  // apb answer
  // ----------------------------------------
  logic [31:0] rdata_r;
  logic ready_r;
  logic err_r;
  logic [15:0] rdSel;

  // ----------------------------------------
  // read select
  // ----------------------------------------
  assign rdSel = hitFlags ? flags_r & RCF_FLAGS_MASK :
    hitCtrl ? ctrl_r & RCF_CTRL_MASK : 16'h0000; // R9

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h00000000;
      ready_r <= 1'b0;
      err_r <= 1'b0;
    end else if (clockEnable) begin
      ready_r <= setupPhase;
      err_r <= setupPhase && !hitAny;
      if (setupPhase) begin
        rdata_r <= {16'h0000, rdSel};
      end
    end
  end

  assign prdata = rdata_r;
  assign pready = ready_r;
  assign pslverr = err_r;

  // ----------------------------------------
  // outputs toward the system
  // ----------------------------------------
  logic [15:0] nmi_r;
  logic nmiAny_r;

  always_ff @(posedge clock or negedge porRst_n) begin
    if (!porRst_n) begin
      nmi_r <= 16'h0000;
      nmiAny_r <= 1'b0;
    end else if (clockEnable) begin
      nmi_r <= flags_nxt; // R10
      nmiAny_r <= |flags_nxt; // R10
    end
  end

  // ----------------------------------------
  // output ports
  // ----------------------------------------
  assign nmiFlags = nmi_r;
  assign nmiFlagAny = nmiAny_r;
  assign resetReq = req_r;
  assign highSupEnable = ctrl_r[RCF_HIGH_EN_BIT];
  assign coreSupEnable = ctrl_r[RCF_CORE_EN_BIT];

endmodule

// *** rcf_pkg.sv ***
// package for the reset cause flag register block
package rcf_pkg;

  // ----------------------------------------
  // register indices, byte address is 4x
  // ----------------------------------------
  localparam logic [7:0] RCF_CTRL_IDX = 8'h00;
  localparam logic [7:0] RCF_FLAGS_IDX = 8'h0A;
  localparam logic [9:0] RCF_CTRL_ADDR = {RCF_CTRL_IDX, 2'b00};
  localparam logic [9:0] RCF_FLAGS_ADDR = {RCF_FLAGS_IDX, 2'b00};

  // ----------------------------------------
  // flag field positions
  // ----------------------------------------
  localparam int RCF_DEEP_OFF_BIT = 15;
  localparam int RCF_HIGH_SUP_BIT = 13;
  localparam int RCF_CORE_SUP_BIT = 12;
  localparam int RCF_SOFT_POR_BIT = 10;
  localparam int RCF_RST_PIN_BIT = 9;
  localparam int RCF_SOFT_BOR_BIT = 8;
  localparam logic [15:0] RCF_FLAGS_MASK = 16'hB700;
  localparam logic [15:0] RCF_FLAGS_RESET = 16'h0000;

  // ----------------------------------------
  // control field positions and reset value
  // ----------------------------------------
  localparam int RCF_HIGH_EN_BIT = 6;
  localparam int RCF_CORE_EN_BIT = 5;
  localparam int RCF_SOFT_POR_TRIG_BIT = 3;
  localparam int RCF_SOFT_BOR_TRIG_BIT = 2;
  localparam logic [15:0] RCF_CTRL_MASK = 16'h0060;
  localparam logic [15:0] RCF_CTRL_RESET = 16'h0060;

  // ----------------------------------------
  // synchroniser depth
  // ----------------------------------------
  localparam int RCF_SYNC_STAGES = 2;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic deepOffWake;
    logic highSupTrip;
    logic coreSupTrip;
    logic brownout;
    logic resetPin;
  } rcf_cause_t;

  typedef struct packed {
    logic softPorReq;
    logic softBorReq;
  } rcf_req_t;

endpackage

// *** rcf_reset_cause_flags_assertions.sv ***
// checker for the reset cause flag register
`timescale 1ns/10ps
module rcf_chk
  import rcf_pkg::*;
(
  // watched ports
  input wire logic clock,
  input wire logic rst_n,
  input wire logic porRst_n,
  input wire rcf_cause_t causeIn,
  input wire rcf_req_t resetReq,
  input wire logic [15:0] nmiFlags
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n || !porRst_n);
  deep_set_a:
    assert property ((causeIn.deepOffWake && !causeIn.brownout && !causeIn.highSupTrip)[*4]
      |=> nmiFlags[15]) else $error("deep set");
  deep_clr_a:
    assert property (causeIn.brownout[*4] |=> !nmiFlags[15]) else $error("deep clear");
  high_set_a:
    assert property ((causeIn.highSupTrip && !causeIn.brownout)[*4] |=> nmiFlags[13])
      else $error("high set");
  core_set_a:
    assert property ((causeIn.coreSupTrip && !causeIn.highSupTrip)[*4] |=> nmiFlags[12])
      else $error("core set");
  pin_set_a:
    assert property (causeIn.resetPin[*4] |=> nmiFlags[9]) else $error("pin set");
  por_flag_a:
    assert property (resetReq.softPorReq |=> nmiFlags[10]) else $error("por flag");
  bor_flag_a:
    assert property (resetReq.softBorReq |=> nmiFlags[8]) else $error("bor flag");
  resv_zero_a:
    assert property ((nmiFlags & ~RCF_FLAGS_MASK) == 16'h0000) else $error("reserved set");
  req_pulse_a:
    assert property (resetReq.softPorReq |=> !resetReq.softPorReq) else $error("por pulse");
endmodule

bind rcf_reset_cause_flags rcf_chk u_chk (.clock, .rst_n, .porRst_n, .causeIn, .resetReq, .nmiFlags);

// *** tb.sv ***
// testbench for the reset cause flag register
`timescale 1ns/10ps
module tb;
  import rcf_pkg::*;
  logic clock = 1'b0, rst_n = 1'b0, porRst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, vectorRead = 1'b0, pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] nmiFlags;
  logic clockEnable = 1'b1, highSupEnable, coreSupEnable, nmiFlagAny;
  logic [3:0] pstrb = 4'hF;
  rcf_cause_t causeIn = 5'h00;
  rcf_req_t resetReq;
  logic [4:0] cv [7] = '{5'h10, 5'h02, 5'h08, 5'h0A, 5'h0C, 5'h04, 5'h01};
  logic [15:0] fv [7] = '{16'h8000, 16'h0, 16'h2000, 16'h0, 16'h2000, 16'h1000, 16'h0200};
  int n_errors = 0, num_checks = 0;
  always #2.5 clock = ~clock;
  rcf_reset_cause_flags uut (.clock, .rst_n, .porRst_n, .clockEnable, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .causeIn, .vectorRead,
    .resetReq, .highSupEnable, .coreSupEnable, .nmiFlags, .nmiFlagAny);
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, a};
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task rdchk(input string n, input logic [9:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, rd, e);
  endtask
  task t_reset;
    rdchk("flags", RCF_FLAGS_ADDR, 32'h0);
    rdchk("ctrl", RCF_CTRL_ADDR, 32'h60);
    apb(1'b0, 10'h3FC, 32'h0);
    chk("slverr", {31'h0, err}, 32'h1);
    chk("unmapped", rd, 32'h0);
    chk("enables", {30'h0, highSupEnable, coreSupEnable}, 32'h3);
  endtask
  task t_enable;
    apb(1'b1, RCF_CTRL_ADDR, 32'h20);
    chk("high en", {31'h0, highSupEnable}, 32'h0);
    causeIn <= 5'h18;
    repeat (6) @(posedge clock);
    causeIn <= 5'h00;
    repeat (4) @(posedge clock);
    rdchk("no fail", RCF_FLAGS_ADDR, 32'hA000);
    pstrb <= 4'h1;
    apb(1'b1, RCF_FLAGS_ADDR, 32'h0);
    pstrb <= 4'hF;
    rdchk("lane", RCF_FLAGS_ADDR, 32'hA000);
    clockEnable <= 1'b0;
    vectorRead <= 1'b1;
    @(posedge clock);
    clockEnable <= 1'b1;
    vectorRead <= 1'b0;
    @(posedge clock);
    rdchk("frozen", RCF_FLAGS_ADDR, 32'hA000);
    vectorRead <= 1'b1;
    @(posedge clock);
    vectorRead <= 1'b0;
    @(posedge clock);
    rdchk("vector", RCF_FLAGS_ADDR, 32'h0);
  endtask
  task t_cause;
    for (int i = 0; i < 7; i++) begin
      causeIn <= cv[i];
      repeat (6) @(posedge clock);
      causeIn <= 5'h00;
      repeat (4) @(posedge clock);
      rdchk("cause", RCF_FLAGS_ADDR, {16'h0, fv[i]});
      chk("nmi", {16'h0, nmiFlags}, {16'h0, fv[i]});
      chk("nmi any", {31'h0, nmiFlagAny}, {31'h0, |fv[i]});
      if (i != 0) begin
        vectorRead <= 1'b1;
        @(posedge clock);
        vectorRead <= 1'b0;
        @(posedge clock);
      end
    end
  endtask
  task t_soft;
    apb(1'b1, RCF_CTRL_ADDR, 32'h8);
    chk("por req", {31'h0, resetReq.softPorReq}, 32'h1);
    rdchk("por", RCF_FLAGS_ADDR, 32'h400);
    chk("por req end", {31'h0, resetReq.softPorReq}, 32'h0);
    rdchk("trig", RCF_CTRL_ADDR, 32'h0);
    apb(1'b1, RCF_CTRL_ADDR, 32'h4);
    rdchk("bor", RCF_FLAGS_ADDR, 32'h500);
    apb(1'b1, RCF_FLAGS_ADDR, 32'hFFFF);
    rst_n <= 1'b0;
    @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rdchk("keep", RCF_FLAGS_ADDR, 32'hB700);
    rdchk("ctrl rst", RCF_CTRL_ADDR, 32'h60);
    apb(1'b1, RCF_FLAGS_ADDR, 32'h0);
    rdchk("clear", RCF_FLAGS_ADDR, 32'h0);
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clock);
    porRst_n <= 1'b1;
    rst_n <= 1'b1;
    @(posedge clock);
    t_reset;
    t_cause;
    t_enable;
    t_soft;
    wrap_up;
  end
  initial begin
    #20000;
    n_errors++;
    wrap_up;
  end
endmodule
